// File: logic/nbr_node_regs.sv
// Overview of operation
// R1 - registers at fixed offsets from node base
// R2 - identification reads zero until initialized
// R3 - revision: hardware high byte, firmware low
// R4 - bit 31 ORs error flags, read-only
// R5 - writing node reset starts power-up reset; the code does so only in the running state, not while halted
// R6 - self-test holds bad, blocks access
// R7 - power-low clears reset bit, firmware otherwise
// R8 - halt goes quiet; clear restarts, no test
// R9 - bad flag follows self-test fail
// R10 - set corrected-confirmation flag on event
// R11 - unimplemented positions read zero
// R12 - parity error flag on any cycle
// R13 - write sequence error flag
// R14 - read and write data no_acknowledge flags
// R15 - corrected read data flag
// R16 - no response, read sequence, read error
// R17 - command no_acknowledge after all retries fail
// R18 - transaction timeout flag
// R19 - self-test fail set until test passes; the code also clears it when the host writes one to it
// R20 - log failing commander on listed errors
// R21 - timeout disable suppresses two errors; the code suppresses them only while retries are disabled
// R22 - write one clears flag, zero keeps

`timescale 1ns/1ps

module nbr_node_regs #(
   parameter logic [7:0]  HW_REV       = 8'h01,     // arbitrary value
   parameter logic [15:0] DEV_TYPE     = 16'h5a5a,  // arbitrary value
   parameter logic [31:0] SELFTEST_MAX = 32'h000f_4240  // self-test limit in clocks
) (
   input  wire logic                        i_core_clk,
   input  wire logic                        i_host_node_reset,
   // register access from the system bus
   input  wire logic                        i_reg_req,
   input  wire logic                        i_reg_wr,
   input  wire logic [nbr_pkg::ADDR_W-1:0]  i_reg_addr,
   input  wire logic [nbr_pkg::DATA_W-1:0]  i_reg_wdata,
   output logic                             o_reg_ack,
   output logic      [nbr_pkg::DATA_W-1:0]  o_reg_rdata,
   // error events from the bus interface logic
   input  wire logic                        i_evt_corr_cnf,
   input  wire logic                        i_evt_parity,
   input  wire logic                        i_evt_wr_seq,
   input  wire logic                        i_evt_rd_no_acknowledge,
   input  wire logic                        i_evt_wr_no_acknowledge,
   input  wire logic                        i_evt_crd,
   input  wire logic                        i_evt_no_rd_resp,
   input  wire logic                        i_evt_rd_seq,
   input  wire logic                        i_evt_rd_err,
   input  wire logic                        i_evt_cmd_no_acknowledge,
   input  wire logic                        i_evt_txn_tmo,
   input  wire logic [nbr_pkg::CID_W-1:0]   i_evt_cid,
   // retry policy of the bus logic
   input  wire logic                        i_retry_dis,
   // firmware side
   input  wire logic                        i_selftest_pass,
   input  wire logic                        i_fw_rev_load,
   input  wire logic [7:0]                  i_fw_rev,
   input  wire logic                        i_fw_rst_done,
   // node control outputs
   output logic                             o_bad_line,
   output logic                             o_access_block,
   output logic                             o_selftest_start,
   output logic                             o_quiet,
   output logic                             o_restart
);
   import nbr_pkg::*;

   // ***********************************************
   // state
   // ***********************************************

   typedef struct packed {
      nbr_state_e          state;      // operating state
      logic [31:0]         test_cnt;   // self-test time counter
      logic                node_rst;   // host node reset bit
      logic                node_halt;  // host halt request bit
      logic                bad_flag;   // drives bad line
      logic                selftest_fail_flag;        // self-test fail
      logic [31:0]         err;        // error flags at their positions
      logic [CID_W-1:0]    failing_commander_id;       // failing commander
      logic                tmo_dis;    // timeout report disable
      logic                id_valid;   // identification loaded
      logic [7:0]          fw_rev;     // stored firmware revision
      logic                ack;        // access answer
      logic [31:0]         rdata;      // read data
      logic                st_start;   // self-test start pulse
      logic                quiet;      // halted
      logic                restart;    // restart pulse
      logic                blk;        // access blocked while testing
   } nbr_regs_s;

   nbr_regs_s st_reg;                  // registered state
   nbr_regs_s st_next;                 // next state

   // decode and read helpers
   logic        wr_hit;                // write to bus error register
   logic        taken;                 // request taken this cycle
   logic [31:0] evt_vec;               // events at flag positions
   logic [31:0] clr_vec;               // write-one-to-clear mask
   logic [31:0] ber_read;              // bus error read view
   logic [31:0] id_read;               // identification read view
   logic        sup_tmo;               // timeout reports suppressed

   // ***********************************************
   // event collection
   // ***********************************************

   // gather events at their flag positions
   always_comb begin
      // reports suppressed only with the enable bit and retries off
      sup_tmo = st_reg.tmo_dis & i_retry_dis;  // R21
      // positions without an event source stay low
      evt_vec = ZERO32;
      evt_vec[B_CORR_CNF]   = i_evt_corr_cnf;  // R10
      evt_vec[B_PARITY]     = i_evt_parity;    // R12
      evt_vec[B_WR_SEQ]     = i_evt_wr_seq;    // R13
      evt_vec[B_RD_NO_ACKNOWLEDGE]   = i_evt_rd_no_acknowledge;  // R14
      evt_vec[B_WR_NO_ACKNOWLEDGE]   = i_evt_wr_no_acknowledge;  // R14
      evt_vec[B_CRD]        = i_evt_crd;       // R15
      // the two timeout-class reports obey the suppression
      evt_vec[B_NO_RD_RESP] = i_evt_no_rd_resp & ~sup_tmo; // R16
      evt_vec[B_RD_SEQ]     = i_evt_rd_seq;    // R16
      evt_vec[B_RD_ERR]     = i_evt_rd_err;    // R16
      // the bus logic pulses this only once all retries failed
      evt_vec[B_CMD_NO_ACKNOWLEDGE]  = i_evt_cmd_no_acknowledge; // R17
      evt_vec[B_TXN_TMO]    = i_evt_txn_tmo & ~sup_tmo; // R18
   end

   // ***********************************************
   // register read views
   // ***********************************************

   // identification: zero until the firmware loads it
   always_comb begin
      if (st_reg.id_valid) begin
         // hardware revision, firmware revision, device type
         id_read = {HW_REV, st_reg.fw_rev, DEV_TYPE}; // R3
      end else begin
         // uninitialized node shows all zero
         id_read = ZERO32; // R2
      end
   end

   // bus error: flags, control bits, unused positions zero
   always_comb begin
      ber_read = st_reg.err & ERR_MASK; // R11
      // control and status bits over the flag view
      ber_read[B_SUMMARY]   = |(st_reg.err & ERR_MASK); // R4
      ber_read[B_NODE_RST]  = st_reg.node_rst;
      ber_read[B_NODE_HALT] = st_reg.node_halt;
      ber_read[B_BAD]       = st_reg.bad_flag;
      ber_read[B_STF]       = st_reg.selftest_fail_flag;
      // failing commander is read-only, logged by hardware
      ber_read[B_FAILING_COMMANDER_ID_LO +: CID_W] = st_reg.failing_commander_id;
      ber_read[B_TMO_DIS]   = st_reg.tmo_dis;
   end

   // ***********************************************
   // next state
   // ***********************************************

   always_comb begin
      // pulses default low, everything else holds
      st_next = st_reg;
      st_next.ack      = 1'b0;
      st_next.st_start = 1'b0;
      st_next.restart  = 1'b0;

      // requests are refused while self-test runs
      taken  = i_reg_req & (st_reg.state != ST_TEST); // R6
      wr_hit = taken & i_reg_wr & (i_reg_addr == OFS_BUS_ERR);
      clr_vec = ZERO32;
      if (wr_hit) begin
         // only error flag positions can be cleared
         clr_vec = i_reg_wdata & ERR_MASK; // R22
      end

      // answer and read data, one cycle after the request
      if (taken) begin
         // every taken request is answered once
         st_next.ack   = 1'b1;
         st_next.rdata = ZERO32;
         if (i_reg_wr) begin
            // writes answer with zero data
            st_next.rdata = ZERO32;
         end else if (i_reg_addr == OFS_NODE_ID) begin
            st_next.rdata = id_read; // R1
         end else if (i_reg_addr == OFS_BUS_ERR) begin
            st_next.rdata = ber_read; // R1
         end else if (i_reg_addr == OFS_FAIL_ADDR) begin
            // failing address log is kept outside this bank
            st_next.rdata = ZERO32;
         end else if (i_reg_addr == OFS_CHAR_XCHG) begin
            // character exchange is kept outside this bank
            st_next.rdata = ZERO32;
         end else if (i_reg_addr == OFS_FAIL_EXT) begin
            // address extension is kept outside this bank
            st_next.rdata = ZERO32;
         end else begin
            st_next.rdata = ZERO32; // unmapped offset
         end
      end

      // error flags: a new event wins over a clear
      // reserved and control positions are masked out
      st_next.err = ((st_reg.err & ~clr_vec) | evt_vec) & ERR_MASK; // R22

      // commander logged when a listed flag is newly set
      if (|(evt_vec & FAILING_COMMANDER_ID_MASK & ~st_reg.err)) begin
         // a flag already set keeps the earlier commander
         st_next.failing_commander_id = i_evt_cid; // R20
      end

      // control bits written by the host
      if (wr_hit) begin
         st_next.tmo_dis   = i_reg_wdata[B_TMO_DIS];
         st_next.node_halt = i_reg_wdata[B_NODE_HALT]; // R8
         // fail bit is write-one-to-clear
         if (i_reg_wdata[B_STF]) begin
            st_next.selftest_fail_flag = 1'b0;
         end
      end

      // firmware loads the stored firmware revision
      if (i_fw_rev_load) begin
         // identification becomes visible once loaded
         st_next.fw_rev   = i_fw_rev;
         st_next.id_valid = 1'b1;
      end

      // firmware ends a host node reset
      if (i_fw_rst_done) begin
         // a power-low reset clears it as well
         st_next.node_rst = 1'b0; // R7
      end

      // operating state
      case (st_reg.state)
         // self-test: block access until pass or time out
         ST_TEST: begin
            st_next.test_cnt = st_reg.test_cnt + CNT_ONE;
            if (i_selftest_pass) begin
               // passed: clear fail, open access
               st_next.selftest_fail_flag   = 1'b0; // R19
               st_next.state = ST_RUN;
            end else if (st_reg.test_cnt >= SELFTEST_MAX) begin
               // time out: run on with fail still set
               st_next.selftest_fail_flag   = 1'b1; // R19
               st_next.state = ST_RUN; // R6
            end else begin
               // still testing: keep fail set
               st_next.selftest_fail_flag   = 1'b1; // R19
            end
         end
         // normal running
         ST_RUN: begin
            if (wr_hit && i_reg_wdata[B_NODE_RST]) begin
               // host node reset behaves like power-up
               st_next.node_rst = 1'b1; // R5
               st_next.selftest_fail_flag      = 1'b1; // R19
               // clear every logged error, the commander and the halt and timeout-disable bits
               st_next.err      = ZERO32;
               st_next.failing_commander_id     = '0;
               st_next.tmo_dis  = 1'b0;
               st_next.node_halt = 1'b0;
               st_next.id_valid = 1'b0; // R2
               // restart the self-test timer and announce it
               st_next.test_cnt = ZERO32;
               st_next.st_start = 1'b1; // R6
               st_next.state    = ST_TEST;
            end else if (wr_hit && i_reg_wdata[B_NODE_HALT]) begin
               // halt request: go quiet until cleared
               st_next.quiet = 1'b1; // R8
               st_next.state = ST_HALT;
            end
         end
         // halted: quiet until the host clears the halt bit
         ST_HALT: begin
            if (wr_hit && !i_reg_wdata[B_NODE_HALT]) begin
               // cleared halt: restart without self-test
               st_next.quiet   = 1'b0;
               st_next.restart = 1'b1; // R8
               st_next.state   = ST_RUN;
            end
         end
         default: begin
            // unknown code: fall back to self-test
            st_next.state = ST_TEST;
         end
      endcase

      // bad flag follows self-test fail
      st_next.bad_flag = st_next.selftest_fail_flag; // R9

      // access block is its own register so no decode drives the pin
      st_next.blk = (st_next.state == ST_TEST); // R6
   end

   // ***********************************************
   // state register
   // ***********************************************

   // power-low reset: node reset bit cleared, test restarts
   // the reset branch loads constants only
   always_ff @(posedge i_core_clk or negedge i_host_node_reset) begin
      if (!i_host_node_reset) begin
         st_reg.state     <= ST_TEST;
         st_reg.test_cnt  <= ZERO32;
         st_reg.node_rst  <= 1'b0; // R7
         st_reg.node_halt <= 1'b0;
         st_reg.bad_flag  <= BAD_RST; // R9
         st_reg.selftest_fail_flag       <= STF_RST; // R19
         st_reg.err       <= ZERO32;
         st_reg.failing_commander_id      <= '0;
         st_reg.tmo_dis   <= 1'b0;
         st_reg.id_valid  <= 1'b0;
         st_reg.fw_rev    <= 8'h00;
         st_reg.ack       <= 1'b0;
         st_reg.rdata     <= ZERO32;
         st_reg.st_start  <= 1'b1;
         st_reg.quiet     <= 1'b0;
         st_reg.restart   <= 1'b0;
         st_reg.blk       <= 1'b1; // R6
      end else begin
         st_reg <= st_next;
      end
   end

   // ***********************************************
   // outputs
   // ***********************************************

   // every output is a field of the state register
   always_comb begin
      o_reg_ack        = st_reg.ack;
      o_reg_rdata      = st_reg.rdata;
      o_bad_line       = st_reg.bad_flag; // R9
      o_access_block   = st_reg.blk; // R6
      o_selftest_start = st_reg.st_start;
      o_quiet          = st_reg.quiet;
      o_restart        = st_reg.restart;
   end

endmodule // nbr_node_regs

// File: logic/nbr_pkg.sv
// ***********************************************
// node identification and bus error constants
// ***********************************************
package nbr_pkg;
   localparam int unsigned ADDR_W = 16;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned CID_W  = 6;

   // register byte offsets from node base
   localparam logic [15:0] OFS_NODE_ID   = 16'h0000;
   localparam logic [15:0] OFS_BUS_ERR   = 16'h0004;
   localparam logic [15:0] OFS_FAIL_ADDR = 16'h0008;
   localparam logic [15:0] OFS_CHAR_XCHG = 16'h0010;
   localparam logic [15:0] OFS_FAIL_EXT  = 16'h002c;

   // bus error status bit positions
   localparam int unsigned B_SUMMARY    = 31;
   localparam int unsigned B_NODE_RST   = 30;
   localparam int unsigned B_NODE_HALT  = 29;
   localparam int unsigned B_BAD        = 28;
   localparam int unsigned B_CORR_CNF   = 27;
   localparam int unsigned B_PARITY     = 23;
   localparam int unsigned B_WR_SEQ     = 22;
   localparam int unsigned B_RD_NO_ACKNOWLEDGE   = 21;
   localparam int unsigned B_WR_NO_ACKNOWLEDGE   = 20;
   localparam int unsigned B_CRD        = 19;
   localparam int unsigned B_NO_RD_RESP = 18;
   localparam int unsigned B_RD_SEQ     = 17;
   localparam int unsigned B_RD_ERR     = 16;
   localparam int unsigned B_CMD_NO_ACKNOWLEDGE  = 15;
   localparam int unsigned B_TXN_TMO    = 13;
   localparam int unsigned B_STF        = 10;
   localparam int unsigned B_FAILING_COMMANDER_ID_LO    = 4;
   localparam int unsigned B_TMO_DIS    = 2;

   // write-one-to-clear error flags, and those that log the commander
   localparam logic [31:0] ERR_MASK  = 32'h08ffa000;
   localparam logic [31:0] FAILING_COMMANDER_ID_MASK = 32'h0017e000;

   // reset values and the self-test counter step
   localparam logic        STF_RST  = 1'h1;
   localparam logic        BAD_RST  = 1'h1;
   localparam logic [31:0] ZERO32   = 32'h0000_0000;
   localparam logic [31:0] CNT_ONE  = 32'h0000_0001;

   // node operating states
   typedef enum logic [1:0] {
      ST_TEST,
      ST_RUN,
      ST_HALT
   } nbr_state_e;
endpackage

// File: testbench/nbr_host_model.sv
`timescale 1ns/1ps
// ****************************************
// host master on the system bus
// ****************************************
module nbr_host_model (
   input  wire logic                       i_core_clk,
   input  wire logic                       i_ack,
   input  wire logic [nbr_pkg::DATA_W-1:0] i_rdata,
   output logic                            o_req,
   output logic                            o_wr,
   output logic      [nbr_pkg::ADDR_W-1:0] o_addr,
   output logic      [nbr_pkg::DATA_W-1:0] o_wdata
);
   import nbr_pkg::*;
   initial begin
      o_req = 1'b0;
      o_wr = 1'b0;
      o_addr = '0;
      o_wdata = '0;
   end
   // one-cycle request pulse; released lines show inverted values
   task automatic acc(input logic w, input logic [15:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output bit ok);
      ok = 0;
      rd = '0;
      @(posedge i_core_clk);
      #1;
      o_req = 1'b1;
      o_wr = w;
      o_addr = a;
      o_wdata = d;
      @(posedge i_core_clk);
      #1;
      o_req = 1'b0;
      o_addr = ~a;
      o_wdata = ~d;
      for (int n = 0; n < 4 && !ok; n++) begin
         if (i_ack === 1'b1) begin
            ok = 1;
            rd = i_rdata;
         end else begin
            @(posedge i_core_clk);
            #1;
         end
      end
   endtask
endmodule // nbr_host_model

// File: testbench/nbr_regs_asserts.sv
`timescale 1ns/1ps
// ****************************************
// register bank checker
// ****************************************
module nbr_regs_asserts (
   input wire logic                       i_core_clk,
   input wire logic                       i_host_node_reset,
   input wire logic                       i_reg_req,
   input wire logic                       i_reg_wr,
   input wire logic [nbr_pkg::ADDR_W-1:0] i_reg_addr,
   input wire logic [nbr_pkg::DATA_W-1:0] i_reg_wdata,
   input wire logic                       o_reg_ack,
   input wire logic [nbr_pkg::DATA_W-1:0] o_reg_rdata,
   input wire logic                       i_selftest_pass,
   input wire logic                       o_bad_line,
   input wire logic                       o_access_block,
   input wire logic                       o_selftest_start,
   input wire logic                       o_quiet,
   input wire logic                       o_restart
);
   import nbr_pkg::*;
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_host_node_reset);
   // accepted request, bus error write and read, node running
   wire tk  = i_reg_req && !o_access_block;
   wire bw  = tk && i_reg_wr && i_reg_addr == OFS_BUS_ERR;
   wire br  = tk && !i_reg_wr && i_reg_addr == OFS_BUS_ERR;
   wire run = !o_access_block && !o_quiet;
   wire unm = i_reg_addr == OFS_FAIL_ADDR || i_reg_addr == OFS_CHAR_XCHG ||
              i_reg_addr == OFS_FAIL_EXT;
   property p_ack; tk |=> o_reg_ack; endproperty
   a_ack: assert property (p_ack) else $error("no ack after request");
   property p_no_acknowledge; !tk |=> !o_reg_ack; endproperty
   a_no_acknowledge: assert property (p_no_acknowledge) else $error("ack without request");
   property p_sum; br |=> o_reg_rdata[31] == |(o_reg_rdata & ERR_MASK); endproperty
   a_sum: assert property (p_sum) else $error("summary bit wrong");
   property p_rsv; br |=> (o_reg_rdata & 32'h07005808) == 32'h0; endproperty
   a_rsv: assert property (p_rsv) else $error("unused bits not zero");
   property p_unm; tk && !i_reg_wr && unm |=> o_reg_rdata == 32'h0; endproperty
   a_unm: assert property (p_unm) else $error("other register not zero");
   property p_rst;
      bw && i_reg_wdata[B_NODE_RST] && run |=> o_access_block && o_bad_line && o_selftest_start;
   endproperty
   a_rst: assert property (p_rst) else $error("node reset not started");
   property p_halt;
      bw && i_reg_wdata[B_NODE_HALT] && !i_reg_wdata[B_NODE_RST] && run |=> o_quiet;
   endproperty
   a_halt: assert property (p_halt) else $error("halt not entered");
   property p_rest; bw && !i_reg_wdata[B_NODE_HALT] && o_quiet |=> !o_quiet && o_restart;
   endproperty
   a_rest: assert property (p_rest) else $error("restart missing");
   property p_pass; o_access_block && i_selftest_pass |=> !o_bad_line && !o_access_block;
   endproperty
   a_pass: assert property (p_pass) else $error("pass not taken");
   property p_blk; o_access_block |-> o_bad_line; endproperty
   a_blk: assert property (p_blk) else $error("bad low in self-test");
   c_wr: cover property (bw ##1 o_reg_ack);
   c_rs: cover property (o_restart);
   c_ps: cover property (o_access_block ##1 !o_access_block);
endmodule // nbr_regs_asserts
bind nbr_node_regs nbr_regs_asserts i_chk (.i_core_clk(i_core_clk), .i_host_node_reset(i_host_node_reset),
   .i_reg_req(i_reg_req), .i_reg_wr(i_reg_wr), .i_reg_addr(i_reg_addr),
   .i_reg_wdata(i_reg_wdata), .o_reg_ack(o_reg_ack), .o_reg_rdata(o_reg_rdata),
   .i_selftest_pass(i_selftest_pass), .o_bad_line(o_bad_line),
   .o_access_block(o_access_block), .o_selftest_start(o_selftest_start),
   .o_quiet(o_quiet), .o_restart(o_restart));

// File: testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   import nbr_pkg::*;
   localparam logic [7:0]  HWR = 8'h3c;   // arbitrary value
   localparam logic [15:0] DVT = 16'h1234; // arbitrary value
   logic clk, host_node_reset, req, wr, ack, rdis, pass, fwld, fwdone, bad, blk, sts, quiet, rsto, ok;
   logic [15:0] addr, lf;
   logic [31:0] wdata, rdata, em, d;
   logic [10:0] ev;
   logic [5:0]  cid;
   logic [7:0]  fwrev;
   int checked, failures;
   int bp[11] = '{27, 23, 22, 21, 20, 19, 18, 17, 16, 15, 13};
   int ua[4] = '{8, 16, 44, 64};
   nbr_node_regs #(.HW_REV(HWR), .DEV_TYPE(DVT), .SELFTEST_MAX(32'h0000_0014)) i_nbr_node_regs (
      .i_core_clk(clk), .i_host_node_reset(host_node_reset), .i_reg_req(req), .i_reg_wr(wr), .i_reg_addr(addr),
      .i_reg_wdata(wdata), .o_reg_ack(ack), .o_reg_rdata(rdata), .i_evt_corr_cnf(ev[0]),
      .i_evt_parity(ev[1]), .i_evt_wr_seq(ev[2]), .i_evt_rd_no_acknowledge(ev[3]),
      .i_evt_wr_no_acknowledge(ev[4]), .i_evt_crd(ev[5]), .i_evt_no_rd_resp(ev[6]),
      .i_evt_rd_seq(ev[7]), .i_evt_rd_err(ev[8]), .i_evt_cmd_no_acknowledge(ev[9]),
      .i_evt_txn_tmo(ev[10]), .i_evt_cid(cid), .i_retry_dis(rdis), .i_selftest_pass(pass),
      .i_fw_rev_load(fwld), .i_fw_rev(fwrev), .i_fw_rst_done(fwdone), .o_bad_line(bad),
      .o_access_block(blk), .o_selftest_start(sts), .o_quiet(quiet), .o_restart(rsto));
   nbr_host_model i_nbr_host_model (.i_core_clk(clk), .i_ack(ack), .i_rdata(rdata),
      .o_req(req), .o_wr(wr), .o_addr(addr), .o_wdata(wdata));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task automatic tick();
      @(posedge clk);
      #1;
   endtask
   task automatic chk(string n, logic [31:0] s, logic [31:0] e);
      checked++;
      if (s !== e) begin
         failures++;
         $display("FAIL %s expected %h seen %h", n, e, s);
      end
   endtask
   function automatic logic [31:0] view();
      logic [31:0] v;
      v = em;
      v[31] = |(em & ERR_MASK);
      return v;
   endfunction
   task automatic rd(logic [15:0] a, logic [31:0] e);
      i_nbr_host_model.acc(1'b0, a, 32'h0, d, ok);
      chk("ack", {31'h0, ok}, 32'h1);
      chk("rdata", d, e);
   endtask
   task automatic wrr(logic [31:0] v);
      i_nbr_host_model.acc(1'b1, OFS_BUS_ERR, v, d, ok);
      chk("wack", {31'h0, ok}, 32'h1);
   endtask
   // next value of the stimulus shift register
   function automatic logic [15:0] lfsr(logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   // event pulse with a random commander id, model follows
   task automatic pulse(int k);
      int b;
      b = bp[k];
      lf = lfsr(lf);
      cid = lf[5:0];
      ev[k] = 1'b1;
      tick();
      ev = '0;
      if (!(rdis && em[2] && (b == 18 || b == 13))) begin
         if (FAILING_COMMANDER_ID_MASK[b] && !em[b]) em[9:4] = cid;
         em[b] = 1'b1;
      end
   endtask
   task automatic results();
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   initial begin
      {host_node_reset, rdis, pass, fwld, fwdone, ev, cid, fwrev} = '0;
      lf = 16'h39d2;
      em = 32'h1000_0400;
      repeat (12) @(posedge clk);
      #1 host_node_reset = 1'b1;
      chk("blk", blk, 1);
      chk("bad", bad, 1);
      chk("start", sts, 1);
      i_nbr_host_model.acc(1'b0, OFS_BUS_ERR, 32'h0, d, ok);
      chk("refused", ok, 0);
      pass = 1'b1;
      tick();
      pass = 1'b0;
      em[28] = 0;
      em[10] = 0;
      tick();
      chk("bad", bad, 0);
      rd(OFS_NODE_ID, 32'h0);
      fwrev = 8'h07;
      fwld = 1'b1;
      tick();
      fwld = 1'b0;
      rd(OFS_NODE_ID, {HWR, 8'h07, DVT});
      for (int k = 0; k < 11; k++) begin
         pulse(k);
         rd(OFS_BUS_ERR, view());
         wrr(32'h1 << bp[k]);
         em[bp[k]] = 0;
         rd(OFS_BUS_ERR, view());
      end
      pulse(1);
      wrr(32'h0);
      rd(OFS_BUS_ERR, view());
      wrr(32'h0080_0004);
      em[23] = 0;
      em[2] = 1;
      rdis = 1'b1;
      pulse(6);
      pulse(10);
      rd(OFS_BUS_ERR, view());
      rdis = 1'b0;
      pulse(10);
      rd(OFS_BUS_ERR, view());
      foreach (ua[i]) rd(ua[i][15:0], 32'h0);
      wrr(32'h2000_0004);
      em[29] = 1;
      chk("quiet", quiet, 1);
      rd(OFS_BUS_ERR, view());
      wrr(32'h0000_0004);
      em[29] = 0;
      chk("restart", rsto, 1);
      chk("quiet", quiet, 0);
      wrr(32'h4000_0000);
      em = 32'h5000_0400;
      chk("blk", blk, 1);
      chk("bad", bad, 1);
      chk("start", sts, 1);
      pass = 1'b1;
      tick();
      pass = 1'b0;
      em[28] = 0;
      em[10] = 0;
      rd(OFS_BUS_ERR, view());
      fwdone = 1'b1;
      tick();
      fwdone = 1'b0;
      em[30] = 0;
      rd(OFS_BUS_ERR, view());
      rd(OFS_NODE_ID, 32'h0);
      host_node_reset = 1'b0;
      tick();
      host_node_reset = 1'b1;
      em = 32'h1000_0400;
      for (int n = 0; n < 40 && blk; n++) tick();
      chk("blk", blk, 0);
      chk("bad", bad, 1);
      rd(OFS_BUS_ERR, view());
      results();
   end
endmodule // tb_top
